// ---- shared/srm_regs.svh ----
// readback selector constants: select codes, field positions, word width
// assumes inclusion by the design files by bare name
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH
`define SRM_SEL_FAULT 3'h0
`define SRM_SEL_ONCMD 3'h1
`define SRM_SEL_OCLVL 3'h2
`define SRM_SEL_BLANK 3'h3
`define SRM_SEL_DIRIN 3'h4
`define SRM_SEL_DELAY 3'h5
`define SRM_SEL_PINS 3'h6
`define SRM_SEL_NULL 3'h7
`define SRM_CMD_READBACK 4'h0
`define SRM_CMD_ADDR_MSB 6
`define SRM_CMD_ADDR_LSB 3
`define SRM_WORD_BITS 8
`define SRM_SEL_RESET 3'h7
`endif

// ---- shared/srm_pkg.sv ----
// types of the status readback selector
// assumes srm_regs.svh on the include path
package srm_pkg;
    // fault flags of one output, bit 6 down to bit 1 of the fault word
    typedef struct packed {
        logic overtemperature_flag;
        logic overcurrent_high_flag;
        logic overcurrent_low_flag;
        logic open_load_flag;
        logic undervoltage_flag;
        logic overvoltage_flag;
    } srm_fault_t;
    // programmed settings of one output
    typedef struct packed {
        logic [0:0] oc_high;
        logic [2:0] oc_low;
        logic [1:0] blank_code;
        logic overcurrent_timeout_disable;
        logic open_load_detect_disable;
        logic fast_slew;
        logic sense_high_ratio;
        logic direct_in_disable;
        logic and_or_sel;
        logic current_sense_enable;
        logic serial_on_cmd;
    } srm_outcfg_t;
    // shared settings and live state
    typedef struct packed {
        logic [2:0] turn_on_delay;
        logic [1:0] watchdog_period;
        logic watchdog_expired;
        logic failsafe_state_out0;
        logic failsafe_state_out1;
        logic undervoltage_protect_disable;
        logic overvoltage_protect_disable;
    } srm_common_t;
    typedef enum logic [1:0] {SRM_IDLE, SRM_SHIFT} srm_state_t;
endpackage

// ---- hdl/srm_sync.sv ----
// two-flop synchroniser for a bundle of asynchronous levels
// assumes core_clk is the only clock; reset is synchronous active low
`timescale 1ns/1ps
module srm_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    // first flop feeds only the second
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ---- hdl/srm_readback.sv ----
// serial status readback selector of a dual high-side switch
// assumes the link pins are asynchronous and sampled by core_clk;
// configuration fields and fault sources come from the device core
`timescale 1ns/1ps
`include "srm_regs.svh"
module srm_readback (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic [3:0] input_pin_levels,
    input wire srm_pkg::srm_fault_t fault_in0,
    input wire srm_pkg::srm_fault_t fault_in1,
    input wire srm_pkg::srm_outcfg_t cfg0,
    input wire srm_pkg::srm_outcfg_t cfg1,
    input wire srm_pkg::srm_common_t common,
    input wire logic switch_on0,
    input wire logic switch_on1,
    output logic fault_status_pin,
    output logic [7:0] cmd_word,
    output logic cmd_valid
);
    logic [6:0] sync_q;
    logic [3:0] pins_s;
    logic sclk_s, cs_n_s, sdi_s, sclk_d_r, cs_d_r;
    srm_pkg::srm_state_t state_r;
    logic [7:0] shift_r, word_r, word_nxt;
    logic [2:0] bitcnt_r;
    logic any_bits_r;
    logic [2:0] previous_select_code_r;
    logic out_sel_r;
    srm_pkg::srm_fault_t flt0_r, flt1_r;
    logic fault_sum_r;
    logic fs_r;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, len_ok;
    logic is_readback, any_fault, read_fault;
    srm_pkg::srm_fault_t fsel;
    srm_pkg::srm_outcfg_t csel;

    // asynchronous pins pass two flops first; chip select travels
    // inverted so the cleared flops read as deselected after reset
    srm_sync #(.W(7)) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .d({input_pin_levels, sclk, !cs_n, sdi}),
        .q(sync_q)
    );
    assign pins_s = sync_q[6:3];
    assign sclk_s = sync_q[2];
    assign cs_n_s = !sync_q[1]; // no false select edge after reset
    assign sdi_s = sync_q[0];

    // edge detection on synchronised link signals
    assign sclk_rise = sclk_s && !sclk_d_r && !cs_n_s;
    assign sclk_fall = !sclk_s && sclk_d_r && !cs_n_s;
    assign cs_fall = !cs_n_s && cs_d_r;
    assign cs_rise = cs_n_s && !cs_d_r;
    assign len_ok = (bitcnt_r == 3'h0) && any_bits_r;
    assign is_readback = shift_r[`SRM_CMD_ADDR_MSB:`SRM_CMD_ADDR_LSB]
        == `SRM_CMD_READBACK;

    // per-output selection by stored output bit
    assign fsel = out_sel_r ? flt1_r : flt0_r;
    assign csel = out_sel_r ? cfg1 : cfg0;

    // fault summary sources
    assign any_fault = |{flt0_r, flt1_r, fault_in0, fault_in1};
    assign read_fault = cs_fall &&
        (previous_select_code_r == `SRM_SEL_FAULT);

    // status word mux driven by the stored selection
    always_comb begin
        word_nxt = {out_sel_r, previous_select_code_r, 4'h0};
        case (previous_select_code_r)
            `SRM_SEL_FAULT:
                word_nxt = {out_sel_r, fsel, fault_sum_r};
            `SRM_SEL_ONCMD:
                word_nxt[3:0] = {cfg1.current_sense_enable,
                    cfg1.serial_on_cmd, cfg0.current_sense_enable,
                    cfg0.serial_on_cmd};
            `SRM_SEL_OCLVL:
                word_nxt[3:0] = {csel.oc_high, csel.oc_low};
            `SRM_SEL_BLANK:
                word_nxt[3:0] = {!csel.open_load_detect_disable,
                    !csel.overcurrent_timeout_disable,
                    csel.blank_code};
            `SRM_SEL_DIRIN:
                word_nxt[3:0] = {csel.fast_slew, csel.sense_high_ratio,
                    csel.direct_in_disable, csel.and_or_sel};
            `SRM_SEL_DELAY:
                if (out_sel_r) begin
                    word_nxt[3:0] = {common.failsafe_state_out1,
                        common.watchdog_expired,
                        common.watchdog_period};
                end else begin
                    word_nxt[3:0] = {common.failsafe_state_out0,
                        common.turn_on_delay};
                end
            `SRM_SEL_PINS:
                if (out_sel_r) begin
                    word_nxt[3:0] = {2'h0,
                        common.undervoltage_protect_disable,
                        common.overvoltage_protect_disable};
                end else begin
                    word_nxt[3:0] = pins_s;
                end
            `SRM_SEL_NULL:
                word_nxt = 8'h00;
            default:
                word_nxt = 8'h00;
        endcase
    end

    // link edges and transfer state
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            state_r <= srm_pkg::SRM_IDLE;
            bitcnt_r <= 3'h0;
            any_bits_r <= 1'b0;
            shift_r <= 8'h00;
            word_r <= 8'h00;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_n_s;
            if (cs_fall) begin
                state_r <= srm_pkg::SRM_SHIFT;
                word_r <= word_nxt;
                bitcnt_r <= 3'h0;
                any_bits_r <= 1'b0;
            end else if (cs_rise) begin
                state_r <= srm_pkg::SRM_IDLE;
            end else if (state_r == srm_pkg::SRM_SHIFT) begin
                if (sclk_rise) begin
                    shift_r <= {shift_r[6:0], sdi_s};
                    bitcnt_r <= bitcnt_r + 3'h1;
                    any_bits_r <= 1'b1;
                end
                if (sclk_fall) begin
                    // newest input bit follows, so bits past eight echo
                    word_r <= {word_r[6:0], shift_r[0]};
                end
            end
        end
    end

    // selection and command latch on a valid transfer end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            previous_select_code_r <= `SRM_SEL_RESET;
            out_sel_r <= 1'b0;
            cmd_word <= 8'h00;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= cs_rise && len_ok;
            if (cs_rise && len_ok) begin
                cmd_word <= shift_r;
                out_sel_r <= shift_r[7];
                if (is_readback) begin
                    previous_select_code_r <= shift_r[2:0];
                end
            end
        end
    end

    // latched fault flags, summary bit and fault pin
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flt0_r <= '0;
            flt1_r <= '0;
            fault_sum_r <= 1'b0;
            fs_r <= 1'b0;
        end else begin
            flt0_r <= fault_in0 | (flt0_r & 6'h18);
            flt1_r <= fault_in1 | (flt1_r & 6'h18);
            if (switch_on0) begin
                flt0_r[4:3] <= fault_in0[4:3];
            end
            if (switch_on1) begin
                flt1_r[4:3] <= fault_in1[4:3];
            end
            // a new fault wins over the read clear
            fault_sum_r <= (|{fault_in0, fault_in1}) ||
                (fault_sum_r && !read_fault);
            fs_r <= any_fault;
        end
    end

    assign fault_status_pin = fs_r;
    assign sdo = word_r[7];
    assign sdo_oe = (state_r == srm_pkg::SRM_SHIFT);

    // the returned word tracks the stored selection code
    chk_word_echo: assert property (@(posedge core_clk) disable iff (!nrst)
        cs_fall && previous_select_code_r != `SRM_SEL_NULL
        && previous_select_code_r != `SRM_SEL_FAULT
        |=> word_r[6:4] == $past(previous_select_code_r))
        else $error("select code not echoed");
    chk_word_bit7: assert property (@(posedge core_clk) disable iff (!nrst)
        cs_fall && previous_select_code_r != `SRM_SEL_NULL
        |=> word_r[7] == $past(out_sel_r))
        else $error("bit 7 not output select");
    chk_null_word: assert property (@(posedge core_clk) disable iff (!nrst)
        cs_fall && previous_select_code_r == `SRM_SEL_NULL
        |=> word_r == 8'h00)
        else $error("null word not zero");
    chk_bad_len: assert property (@(posedge core_clk) disable iff (!nrst)
        cs_rise && !len_ok |=> $stable(previous_select_code_r)
        && $stable(out_sel_r) && !cmd_valid)
        else $error("invalid transfer changed selection");
    chk_sel_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        !cs_rise |=> $stable(previous_select_code_r))
        else $error("selection changed outside transfer end");
    chk_tristate: assert property (@(posedge core_clk) disable iff (!nrst)
        cs_rise |=> !sdo_oe)
        else $error("output not released after transfer");
    chk_fault_clr: assert property (@(posedge core_clk) disable iff (!nrst)
        read_fault && !(|{fault_in0, fault_in1}) |=> !fault_sum_r)
        else $error("fault summary not cleared by read");
    chk_oc_latch: assert property (@(posedge core_clk) disable iff (!nrst)
        flt0_r.overcurrent_high_flag && !switch_on0
        |=> flt0_r.overcurrent_high_flag)
        else $error("overcurrent flag not held");
    chk_fs_pin: assert property (@(posedge core_clk) disable iff (!nrst)
        flt0_r.overcurrent_low_flag |=> fault_status_pin)
        else $error("fault pin not asserted");
    chk_load_fault: assert property (@(posedge core_clk) disable iff (!nrst)
        cs_fall && previous_select_code_r == `SRM_SEL_FAULT
        |=> word_r[6:1] == $past(fsel))
        else $error("fault word not loaded");
endmodule

// ---- tb/srm_mcu.sv ----
// controller model driving the serial link of the readback selector
// assumes sclk idles low, sdi taken on rise, sdo moved on fall
`timescale 1ns/1ps
module srm_mcu (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    // link idles deselected with the clock standing low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // one frame of nb bits, the command repeated in every byte
    task automatic xfer(input logic [7:0] cmd, input int nb,
                        output logic [7:0] rx);
        cs_n = 1'b0;
        #200;
        for (int i = 0; i < nb; i++) begin
            sdi = cmd[7 - (i % 8)];
            #100;
            sclk = 1'b1;
            rx = {rx[6:0], sdo};
            #100;
            sclk = 1'b0;
        end
        #100;
        cs_n = 1'b1;
        sdi = ~sdi; // released line never shows a stale level
        #300;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the status readback selector
// assumes srm_pkg compiled first and the controller model srm_mcu
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, cs_n, sdi, sdo, sdo_oe, fault_status_pin, cmd_valid;
    logic switch_on0 = 1'b0;
    logic switch_on1 = 1'b0;
    logic [3:0] input_pin_levels = 4'h0;
    logic [7:0] cmd_word, rx, exp, msk, last_cmd;
    logic sdo_line;
    srm_pkg::srm_fault_t fault_in0 = '0, fault_in1 = '0;
    srm_pkg::srm_outcfg_t cfg0 = '0, cfg1 = '0;
    srm_pkg::srm_common_t common = '0;
    logic [2:0] sel_code = 3'h7;
    logic os = 1'b0;
    logic sum_r = 1'b0;
    logic [1:0] lat0 = 2'h0, lat1 = 2'h0;
    int n_fail = 0, cmp_count = 0, cycles = 0, seed = 25;
    int n_valid = 0, n_sent = 0, n_retry = 0;

    always #12.5 core_clk = ~core_clk;

    srm_readback dut (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .input_pin_levels(input_pin_levels), .fault_in0(fault_in0),
        .fault_in1(fault_in1), .cfg0(cfg0), .cfg1(cfg1), .common(common),
        .switch_on0(switch_on0), .switch_on1(switch_on1),
        .fault_status_pin(fault_status_pin), .cmd_word(cmd_word),
        .cmd_valid(cmd_valid));
    // a released output shows the inverse, so a late enable is caught
    assign sdo_line = sdo_oe ? sdo : !sdo;
    srm_mcu mcu (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line));

    // cycle ceiling and count of command strobes
    always @(posedge core_clk) begin
        cycles++;
        if (cmd_valid === 1'b1)
            n_valid++;
        if (cycles == 40000) begin
            n_fail++;
            close_out();
        end
    end

    // expected status word for a stored code and output select
    function automatic logic [7:0] exp_word(logic [2:0] c, logic s);
        srm_pkg::srm_outcfg_t g;
        logic [5:0] f;
        g = s ? cfg1 : cfg0;
        f = (s ? fault_in1 : fault_in0) | {1'b0, s ? lat1 : lat0, 3'h0};
        case (c)
            3'h0: return {s, f, sum_r};
            3'h1: return {s, 3'h1, cfg1.current_sense_enable,
                cfg1.serial_on_cmd, cfg0.current_sense_enable,
                cfg0.serial_on_cmd};
            3'h2: return {s, 3'h2, g.oc_high, g.oc_low};
            3'h3: return {s, 3'h3, ~g.open_load_detect_disable,
                ~g.overcurrent_timeout_disable, g.blank_code};
            3'h4: return {s, 3'h4, g.fast_slew, g.sense_high_ratio,
                g.direct_in_disable, g.and_or_sel};
            3'h5: return s ? {s, 3'h5, common.failsafe_state_out1,
                common.watchdog_expired, common.watchdog_period}
                : {s, 3'h5, common.failsafe_state_out0,
                common.turn_on_delay};
            3'h6: return s ? {s, 3'h6, 2'h0,
                common.undervoltage_protect_disable,
                common.overvoltage_protect_disable}
                : {s, 3'h6, input_pin_levels};
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input string nm, input logic [7:0] got,
                         input logic [7:0] ex);
        cmp_count++;
        if (got !== ex) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // codes and selects in turn first, then random traffic
    initial begin
        logic [7:0] cmd;
        int nb;
        repeat (3) @(posedge core_clk);
        #2;
        nrst = 1'b1;
        last_cmd = 8'h00;
        for (int i = 0; i < 160; i++) begin
            @(posedge core_clk);
            #2;
            fault_in0 = '0;
            fault_in1 = '0;
            switch_on0 = (($random(seed) & 7) == 0) && n_retry < 24;
            switch_on1 = (($random(seed) & 7) == 0) && n_retry < 24;
            @(posedge core_clk);
            #2;
            // retries into a latched overcurrent are capped
            n_retry += int'(switch_on0 && lat0 != 2'h0);
            n_retry += int'(switch_on1 && lat1 != 2'h0);
            if (switch_on0)
                lat0 = 2'h0;
            if (switch_on1)
                lat1 = 2'h0;
            switch_on0 = 1'b0;
            switch_on1 = 1'b0;
            fault_in0 = 6'($random(seed) & $random(seed) & $random(seed));
            fault_in1 = 6'($random(seed) & $random(seed) & $random(seed));
            cfg0 = srm_pkg::srm_outcfg_t'($random(seed));
            cfg1 = srm_pkg::srm_outcfg_t'($random(seed));
            common = srm_pkg::srm_common_t'($random(seed));
            input_pin_levels = 4'($random(seed));
            lat0 |= fault_in0[4:3];
            lat1 |= fault_in1[4:3];
            sum_r |= |{fault_in0, fault_in1};
            cmd = 8'($random(seed)) & 8'h87;
            if (i < 16)
                cmd = {i[3], 4'h0, i[2:0]};
            else if (($random(seed) & 3) == 0)
                cmd[6:3] = 4'h1 | 4'($random(seed));
            nb = (i % 7 == 6) ? 7 : (i % 11 == 10) ? 16 :
                 (i % 13 == 12) ? 12 : 8;
            exp = exp_word(sel_code, os);
            msk = (sel_code == 3'h7) ? 8'h07 : 8'hFF;
            repeat (4) @(posedge core_clk);
            #2;
            mcu.xfer(cmd, nb, rx);
            if (nb == 16)
                check("echo", rx, cmd);
            else if (nb == 8)
                check("status", rx & msk, exp & msk);
            if (sel_code == 3'h0)
                sum_r = |{fault_in0, fault_in1};
            if (nb % 8 == 0) begin
                n_sent++;
                os = cmd[7];
                last_cmd = cmd;
                if (cmd[6:3] == 4'h0)
                    sel_code = cmd[2:0];
            end
            check("cmd_word", cmd_word, last_cmd);
            check("sdo_oe", {7'h0, sdo_oe}, 8'h00);
            check("fault pin", {7'h0, fault_status_pin},
                {7'h0, |{fault_in0, fault_in1, lat0, lat1}});
        end
        check("strobes", 8'(n_valid), 8'(n_sent));
        close_out();
    end
endmodule
